// file: pkg/ptb_pkg.sv
// Package: register map, field layout and types of the primary time base control
package ptb_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PERIOD = 8'h04;
  localparam logic [7:0] ADDR_COMPARE = 8'h08;
  localparam logic [7:0] ADDR_MODES = 8'h0C;
  localparam logic [7:0] ADDR_GEN_BASE = 8'h10;
  localparam logic [7:0] GEN_STRIDE = 8'h08;
  localparam logic [7:0] GEN_TRIG_OFS = 8'h04;
  localparam int NUM_GEN = 4;
  // Control register fields
  localparam int BIT_ENABLE = 15;
  localparam int BIT_UNUSED14 = 14;
  localparam int BIT_IDLE_STOP = 13;
  localparam int BIT_PENDING = 12;
  localparam int BIT_IRQ_EN = 11;
  localparam int BIT_IMM_UPD = 10;
  localparam int BIT_SYNC_POL = 9;
  localparam int BIT_SYNC_OEN = 8;
  localparam int BIT_SYNC_EN = 7;
  localparam int SRC_LSB = 4;
  localparam int PS_LSB = 0;
  localparam int FRAC_BITS = 3;
  // Reset values
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [12:0] PERIOD_RESET = 13'h0000;
  localparam logic [12:0] COMPARE_RESET = 13'h0000;
  localparam logic [7:0] MODES_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [2:0] SRC_SYNC_PIN = 3'h0;
  // Generator output modes
  typedef enum logic [1:0] {
    MODE_EDGE = 2'b00,
    MODE_COMPL = 2'b01,
    MODE_PUSH_PULL = 2'b10,
    MODE_VAR_PHASE = 2'b11
  } gen_mode_t;
  // High-side / low-side output pair
  typedef struct packed {
    logic high;
    logic low;
  } pwm_pair_t;
  // Per-generator settings
  typedef struct packed {
    logic [15:0] phase;
    logic [15:0] duty;
    logic [15:0] trig;
  } gen_cfg_t;
endpackage

// file: logic/power_pwm_primary_time_base_ctrl.sv
// Power PWM primary time base, special event logic and four output generators
`timescale 1ns/1ns
module power_pwm_primary_time_base_ctrl (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic pll_clock_ok,
  input wire logic cpu_idle,
  input wire logic sync_input_pin,
  output logic sync_output_pin,
  output logic special_event_trigger,
  output logic special_event_irq,
  output logic [3:0] adc_trigger,
  output ptb_pkg::pwm_pair_t [3:0] gen_pairs
);
  import ptb_pkg::*;

  // ==========================================================
  // Reset release
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ==========================================================
  // Pin synchronisers
  // Control word is read by the sync edge detector below
  logic [15:0] ctrl_q;
  logic pll_s1_q;
  logic pll_s2_q;
  logic sync_s1_q;
  logic sync_s2_q;
  logic sync_act_prev_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pll_s1_q <= 1'b0;
      pll_s2_q <= 1'b0;
      sync_s1_q <= 1'b0;
      sync_s2_q <= 1'b0;
      sync_act_prev_q <= 1'b0;
    end else begin
      pll_s1_q <= pll_clock_ok;
      pll_s2_q <= pll_s1_q;
      sync_s1_q <= sync_input_pin;
      sync_s2_q <= sync_s1_q;
      sync_act_prev_q <= sync_s2_q ^ ctrl_q[BIT_SYNC_POL];
    end
  end

  // ==========================================================
  // Register file
  logic [12:0] period_q;
  logic [12:0] act_period_q;
  logic [12:0] compare_q;
  logic [7:0] modes_q;
  gen_cfg_t [3:0] gen_cfg_q;
  logic pending_q;
  logic wr_go;
  logic rd_go;
  logic [31:0] wmask;
  logic [31:0] rd_mux;
  logic sel_ctrl;
  logic sel_period;
  logic sel_compare;
  logic sel_modes;
  logic [3:0] sel_gen_a;
  logic [3:0] sel_gen_b;

  // Read data captured on the taking edge, writes land in the accept cycle
  assign wr_go = avs_write && !avs_waitrequest;
  assign rd_go = avs_read && avs_waitrequest;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign sel_ctrl = avs_address == ADDR_CTRL;
  assign sel_period = avs_address == ADDR_PERIOD;
  assign sel_compare = avs_address == ADDR_COMPARE;
  assign sel_modes = avs_address == ADDR_MODES;

  logic [15:0] ctrl_rd;
  assign ctrl_rd = {ctrl_q[15], 1'b0, ctrl_q[13], pending_q, ctrl_q[11:0]};

  // Merge write data into a current value under byte enables
  function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (cur & ~m) | (nw & m);
  endfunction

  logic [31:0] ctrl_nx, period_nx, compare_nx, modes_nx;
  assign ctrl_nx = merge({16'h0000, ctrl_q}, avs_writedata, wmask);
  assign period_nx = merge({16'h0000, period_q, 3'h0}, avs_writedata, wmask);
  assign compare_nx = merge({16'h0000, compare_q, 3'h0}, avs_writedata, wmask);
  assign modes_nx = merge({24'h000000, modes_q}, avs_writedata, wmask);

  // ==========================================================
  // Time base
  logic run;
  logic tick;
  logic wrap;
  logic sync_edge;
  logic ev_match;
  logic ev_out;
  logic [15:0] tb_q;
  logic [15:0] per_full;
  logic [3:0] ps_cnt_q;
  assign run = ctrl_q[BIT_ENABLE] && pll_s2_q;
  assign tick = run && !(cpu_idle && ctrl_q[BIT_IDLE_STOP]);
  assign per_full = {act_period_q, 3'h0};
  assign wrap = tick && (tb_q >= per_full);
  assign sync_edge = ctrl_q[BIT_SYNC_EN] && (ctrl_q[SRC_LSB +: 3] == SRC_SYNC_PIN)
                     && (sync_s2_q ^ ctrl_q[BIT_SYNC_POL]) && !sync_act_prev_q;
  assign ev_match = tick && (tb_q == {compare_q, 3'h0});
  assign ev_out = ev_match && (ps_cnt_q == ctrl_q[PS_LSB +: 4]);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
      period_q <= PERIOD_RESET;
      act_period_q <= PERIOD_RESET;
      compare_q <= COMPARE_RESET;
      modes_q <= MODES_RESET;
      pending_q <= 1'b0;
    end else begin
      if (wr_go && sel_ctrl) begin
        ctrl_q <= ctrl_nx[15:0];
      end
      if (wr_go && sel_period) begin
        period_q <= period_nx[15:3];
      end
      if (wr_go && sel_period && ctrl_q[BIT_IMM_UPD]) begin
        act_period_q <= period_nx[15:3];
      end else if (wrap || !run) begin
        act_period_q <= period_q;
      end
      if (wr_go && sel_compare) begin
        compare_q <= compare_nx[15:3];
      end
      if (wr_go && sel_modes) begin
        modes_q <= modes_nx[7:0];
      end
      if (ev_out) begin
        pending_q <= 1'b1;
      end else if (wr_go && sel_ctrl && avs_byteenable[1]) begin
        pending_q <= avs_writedata[BIT_PENDING];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tb_q <= WORD_RESET;
      ps_cnt_q <= 4'h0;
      sync_output_pin <= 1'b0;
      special_event_trigger <= 1'b0;
      special_event_irq <= 1'b0;
    end else begin
      if (!run || wrap || (tick && sync_edge)) begin
        tb_q <= WORD_RESET;
      end else if (tick) begin
        tb_q <= tb_q + 16'h0001;
      end
      if (!run || ev_out) begin
        ps_cnt_q <= 4'h0;
      end else if (ev_match) begin
        ps_cnt_q <= ps_cnt_q + 4'h1;
      end
      sync_output_pin <= ctrl_q[BIT_SYNC_OEN] && wrap;
      special_event_trigger <= ev_out;
      special_event_irq <= pending_q && ctrl_q[BIT_IRQ_EN];
    end
  end

  // ==========================================================
  // Generators
  logic [3:0][31:0] gen_rd_a;
  logic [3:0][31:0] gen_rd_b;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_GEN; gi++) begin : g_gen
      localparam logic [7:0] OFS_A = ADDR_GEN_BASE + 8'(gi) * GEN_STRIDE;
      logic [16:0] sum;
      logic [16:0] per1;
      logic [15:0] cnt;
      logic [15:0] duty_eff;
      logic act;
      logic pp_q;
      logic [31:0] nx_a;
      logic [31:0] nx_b;
      gen_mode_t mode;
      assign mode = gen_mode_t'(modes_q[2*gi +: 2]);
      assign sel_gen_a[gi] = avs_address == OFS_A;
      assign sel_gen_b[gi] = avs_address == (OFS_A + GEN_TRIG_OFS);
      assign gen_rd_a[gi] = {gen_cfg_q[gi].phase, gen_cfg_q[gi].duty};
      assign gen_rd_b[gi] = {16'h0000, gen_cfg_q[gi].trig};
      assign nx_a = merge(gen_rd_a[gi], avs_writedata, wmask);
      assign nx_b = merge(gen_rd_b[gi], avs_writedata, wmask);
      // Phase-shifted local count, wrapped into the active period
      assign sum = {1'b0, tb_q} + {1'b0, gen_cfg_q[gi].phase};
      assign per1 = {1'b0, per_full} + 17'h00001;
      assign cnt = (sum >= per1) ? 16'(sum - per1) : sum[15:0];
      // Variable phase: duty fixed at half the period
      assign duty_eff = (mode == MODE_VAR_PHASE) ? per1[16:1] : gen_cfg_q[gi].duty;
      assign act = cnt < duty_eff;

      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          gen_cfg_q[gi] <= '0;
          pp_q <= 1'b0;
          gen_pairs[gi] <= '0;
          adc_trigger[gi] <= 1'b0;
        end else begin
          if (wr_go && sel_gen_a[gi]) begin
            gen_cfg_q[gi].phase <= nx_a[31:16];
            gen_cfg_q[gi].duty <= nx_a[15:0];
          end
          if (wr_go && sel_gen_b[gi]) begin
            gen_cfg_q[gi].trig <= nx_b[15:0];
          end
          if (!run) begin
            pp_q <= 1'b0;
          end else if (tick && cnt == WORD_RESET) begin
            pp_q <= !pp_q;
          end
          adc_trigger[gi] <= tick && cnt == gen_cfg_q[gi].trig;
          if (!run) begin
            gen_pairs[gi] <= '0;
          end else if (tick) begin
            case (mode)
              MODE_EDGE: gen_pairs[gi] <= '{high: act, low: 1'b0};
              MODE_COMPL: gen_pairs[gi] <= '{high: act, low: !act};
              MODE_PUSH_PULL: gen_pairs[gi] <= '{high: act && !pp_q, low: act && pp_q};
              MODE_VAR_PHASE: gen_pairs[gi] <= '{high: act, low: !act};
              default: gen_pairs[gi] <= '0;
            endcase
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Read mux and bus handshake
  always_comb begin
    rd_mux = 32'h00000000;
    if (sel_ctrl) begin
      rd_mux = {16'h0000, ctrl_rd};
    end
    if (sel_period) begin
      rd_mux = {16'h0000, period_q, 3'h0};
    end
    if (sel_compare) begin
      rd_mux = {16'h0000, compare_q, 3'h0};
    end
    if (sel_modes) begin
      rd_mux = {24'h000000, modes_q};
    end
    for (int k = 0; k < NUM_GEN; k++) begin
      if (sel_gen_a[k]) begin
        rd_mux = gen_rd_a[k];
      end
      if (sel_gen_b[k]) begin
        rd_mux = gen_rd_b[k];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (rd_go) begin
        avs_readdata <= rd_mux;
      end
    end
  end
endmodule

// file: dv/ptb_checker.sv
// Concurrent checks on the time base control block ports
`timescale 1ns/1ns
module ptb_checker (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic pll_clock_ok,
  input wire logic cpu_idle,
  input wire logic special_event_trigger,
  input wire logic [3:0] adc_trigger,
  input wire ptb_pkg::pwm_pair_t [3:0] gen_pairs
);
  import ptb_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ==========================================
  // Sequences
  sequence running;
    !cpu_idle [*3];
  endsequence
  sequence pll_gone;
    !pll_clock_ok [*6];
  endsequence
  sequence read_done(logic [7:0] a);
    avs_read && !avs_waitrequest && avs_address == a;
  endsequence
  // ==========================================
  // Properties
  wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
  wait_short_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  unused_bit_a: assert property (read_done(ADDR_CTRL) |-> avs_readdata[14] == 1'b0)
    else $error("control bit 14 read as one");
  period_frac_a: assert property (read_done(ADDR_PERIOD) |-> avs_readdata[2:0] == 3'h0)
    else $error("period low bits not zero");
  compare_frac_a: assert property (read_done(ADDR_COMPARE) |-> avs_readdata[2:0] == 3'h0)
    else $error("compare low bits not zero");
  unmapped_read_a: assert property (avs_read && !avs_waitrequest && avs_address >= 8'h30
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  pll_off_a: assert property (pll_gone |-> gen_pairs == '0 && !special_event_trigger)
    else $error("outputs active without pll clock");
  trig_pulse_a: assert property (running ##0 special_event_trigger |=> !special_event_trigger)
    else $error("special event trigger wider than one cycle");
  adc_pulse_a: assert property (running ##0 adc_trigger[0] |=> !adc_trigger[0])
    else $error("adc trigger wider than one cycle");
  reset_quiet_a: assert property ($rose(rst_b) |-> avs_waitrequest && gen_pairs == '0)
    else $error("outputs not quiet at reset release");
endmodule
bind power_pwm_primary_time_base_ctrl ptb_checker chk (.*);

// file: dv/converter_model.sv
// Converter stage model: counts on-time of each switch leg
`timescale 1ns/1ns
module converter_model (
  input wire logic clk_sys,
  input wire logic clear,
  input wire ptb_pkg::pwm_pair_t [3:0] gen_pairs,
  output logic [3:0][15:0] hi_cnt,
  output logic [3:0][15:0] lo_cnt,
  output logic [15:0] overlap_cnt
);
  import ptb_pkg::*;
  always @(posedge clk_sys) begin
    if (clear) begin
      hi_cnt <= '0;
      lo_cnt <= '0;
      overlap_cnt <= '0;
    end else begin
      for (int i = 0; i < NUM_GEN; i++) begin
        hi_cnt[i] <= hi_cnt[i] + 16'(gen_pairs[i].high);
        lo_cnt[i] <= lo_cnt[i] + 16'(gen_pairs[i].low);
      end
      // Shoot-through on the push-pull pair
      overlap_cnt <= overlap_cnt + 16'(gen_pairs[1].high & gen_pairs[1].low);
    end
  end
endmodule

// file: dv/power_pwm_primary_time_base_ctrl_tb.sv
// Self-checking bench for the primary time base control block
`timescale 1ns/1ns
module power_pwm_primary_time_base_ctrl_tb;
  import ptb_pkg::*;
  logic clk_sys = 0, rst_b = 0, avs_read = 0, avs_write = 0, pll_clock_ok = 1, cpu_idle = 0;
  logic sync_input_pin = 0, clear = 0, avs_waitrequest, sync_output_pin;
  logic special_event_trigger, special_event_irq;
  logic [7:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata;
  logic [3:0] adc_trigger;
  pwm_pair_t [3:0] gen_pairs;
  logic [3:0][15:0] hi_cnt, lo_cnt;
  logic [15:0] overlap_cnt;
  logic [31:0] exp_q[$];
  int n_errors = 0, checks_done = 0;
  logic sync_drive = 0;
  int sync_ph = 0;
  always #4 clk_sys = ~clk_sys;
  // Sync pin pattern while enabled: one low cycle in every five
  always @(posedge clk_sys) begin
    sync_ph <= (sync_ph == 4) ? 0 : sync_ph + 1;
    if (sync_drive) sync_input_pin <= (sync_ph != 0);
  end
  power_pwm_primary_time_base_ctrl dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pll_clock_ok(pll_clock_ok), .cpu_idle(cpu_idle),
    .sync_input_pin(sync_input_pin), .sync_output_pin(sync_output_pin),
    .special_event_trigger(special_event_trigger), .special_event_irq(special_event_irq),
    .adc_trigger(adc_trigger), .gen_pairs(gen_pairs));
  converter_model conv (.clk_sys(clk_sys), .clear(clear), .gen_pairs(gen_pairs),
    .hi_cnt(hi_cnt), .lo_cnt(lo_cnt), .overlap_cnt(overlap_cnt));
  // ==========================================
  // Checking
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  always @(posedge clk_sys) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) check_val(avs_readdata, 32'hFFFFFFFF);
      else check_val(avs_readdata, exp_q.pop_front());
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // Bus and timing helpers
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      n_errors++;
      tally_and_finish();
    end else begin
      avs_read <= 0;
      avs_write <= 0;
      @(posedge clk_sys);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic gap(output int c);
    c = 0;
    do begin
      @(posedge clk_sys);
      c++;
    end while (special_event_trigger !== 1'b1 && c < 400);
    if (c >= 400) begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  task automatic edges(output int t, output int s);
    logic pt, ps;
    t = 0;
    s = 0;
    @(posedge clk_sys);
    pt = special_event_trigger;
    ps = sync_output_pin;
    repeat (45) begin
      @(posedge clk_sys);
      if (!sync_drive) sync_input_pin <= 1'($urandom);
      if (special_event_trigger === 1'b1 && pt !== 1'b1) t++;
      if (sync_output_pin === 1'b1 && ps !== 1'b1) s++;
      pt = special_event_trigger;
      ps = sync_output_pin;
    end
  endtask
  // ==========================================
  // Scenarios
  logic [15:0] cc[5] = '{16'h8100, 16'hA100, 16'h8100, 16'h8100, 16'h0100};
  logic ci[5] = '{0, 1, 1, 0, 0};
  logic cp[5] = '{1, 1, 1, 0, 1};
  int ce[5] = '{5, 0, 5, 0, 0};
  initial begin
    int c, t, s, ps;
    logic [31:0] rv;
    void'($urandom(6618));
    repeat (10) @(posedge clk_sys);
    rst_b <= 1;
    repeat (3) @(posedge clk_sys);
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_PERIOD, 32'h0);
    bus(1, ADDR_CTRL, 32'h7F8F);
    rd(ADDR_CTRL, 32'h3F8F);
    rv = $urandom;
    bus(1, ADDR_PERIOD, rv);
    rd(ADDR_PERIOD, {16'h0, rv[15:3], 3'h0});
    bus(1, ADDR_COMPARE, 32'hFFFF);
    rd(ADDR_COMPARE, 32'hFFF8);
    bus(1, 8'h40, 32'hFFFF);
    rd(8'h40, 32'h0);
    $display("test registers done");
    bus(1, ADDR_PERIOD, 32'h8);
    bus(1, ADDR_COMPARE, 32'h0);
    for (int i = 0; i < 4; i++) begin
      ps = (i == 3) ? 15 : i;
      bus(1, ADDR_CTRL, 32'h8000 | ps);
      gap(c);
      gap(c);
      check_val(32'(c), 32'(9 * (ps + 1)));
    end
    $display("test postscale done");
    bus(1, ADDR_CTRL, 32'h8800);
    gap(c);
    bus(1, ADDR_COMPARE, 32'hFFF8);
    check_val({31'h0, special_event_irq}, 32'h1);
    rd(ADDR_CTRL, 32'h9800);
    bus(1, ADDR_CTRL, 32'h8000);
    rd(ADDR_CTRL, 32'h8000);
    bus(1, ADDR_CTRL, 32'h9000);
    check_val({31'h0, special_event_irq}, 32'h0);
    bus(1, ADDR_COMPARE, 32'h0);
    $display("test pending done");
    for (int i = 0; i < 5; i++) begin
      cpu_idle <= ci[i];
      pll_clock_ok <= cp[i];
      bus(1, ADDR_CTRL, 32'(cc[i]));
      repeat (6) @(posedge clk_sys);
      edges(t, s);
      check_val(32'(t), 32'(ce[i]));
      check_val(32'(s), 32'(ce[i]));
    end
    cpu_idle <= 0;
    pll_clock_ok <= 1;
    sync_drive <= 1;
    bus(1, ADDR_CTRL, 32'h8380);
    repeat (6) @(posedge clk_sys);
    edges(t, s);
    check_val(32'(t), 32'd9);
    check_val(32'(s), 32'd0);
    gap(c);
    check_val(32'(sync_ph), 32'd0);
    sync_drive <= 0;
    $display("test run modes done");
    bus(1, ADDR_MODES, 32'h08);
    bus(1, 8'h10, 32'h3);
    bus(1, 8'h18, 32'h3);
    bus(1, ADDR_CTRL, 32'h8000);
    repeat (20) @(posedge clk_sys);
    clear <= 1;
    @(posedge clk_sys);
    clear <= 0;
    t = 0;
    repeat (36) begin
      @(posedge clk_sys);
      if (adc_trigger[0] === 1'b1) t++;
    end
    #1;
    check_val(32'(hi_cnt[0]), 32'd12);
    check_val(32'(hi_cnt[1]), 32'd6);
    check_val(32'(lo_cnt[1]), 32'd6);
    check_val(32'(overlap_cnt), 32'd0);
    check_val(32'(t), 32'd4);
    @(posedge clk_sys);
    $display("test generators done");
    tally_and_finish();
  end
endmodule
